// ### verilog/pff_pkg.sv
/*
 Package for the power and flat field state control block: state encodings,
 status bit positions, temperature thresholds and timing constants.
 Assumes a 40 MHz system clock and temperatures in signed units of 0.01 degC.
*/
`default_nettype none
package pff_pkg;
  // Power states
  typedef enum logic [2:0] {
    PFF_PWR_OFF,
    PFF_PWR_UNINIT,
    PFF_PWR_ON,
    PFF_PWR_SHUTDOWN,
    PFF_PWR_OVERTEMP
  } pff_pwr_t;

  // Correction modes as written by software
  localparam logic [1:0] PFF_MODE_EXTERNAL = 2'h0;
  localparam logic [1:0] PFF_MODE_MANUAL   = 2'h1;
  localparam logic [1:0] PFF_MODE_AUTO     = 2'h2;

  // Correction state codes in the status word
  localparam logic [1:0] PFF_FST_NOT_CMD  = 2'h0;
  localparam logic [1:0] PFF_FST_IMMINENT = 2'h1;
  localparam logic [1:0] PFF_FST_BUSY     = 2'h2;
  localparam logic [1:0] PFF_FST_DONE     = 2'h3;

  // Status word bit positions
  localparam int PFF_ST_DESIRED_BIT  = 3;
  localparam int PFF_ST_FSTATE_LSB   = 4;
  localparam int PFF_ST_LOCKOUT_BIT  = 15;
  localparam int PFF_ST_SHUTDOWN_BIT = 20;

  // Temperatures in 0.01 degC
  localparam logic signed [15:0] PFF_T_OVER    = 16'sh1F40; // 80.00 degC
  localparam logic signed [15:0] PFF_T_LOW     = -16'sh03E8; // -10.00 degC
  localparam logic signed [15:0] PFF_T_HIGH    = 16'sh1964; // 65.00 degC
  localparam logic [15:0]        PFF_T_DELTA   = 16'h012C; // 3.00 degC

  // Timing
  localparam int  PFF_CLK_HZ        = 40000000;
  localparam int  PFF_OT_SECONDS    = 10;
  localparam int  PFF_FFC_MINUTES   = 5;
  localparam longint PFF_OT_CYCLES  = longint'(PFF_OT_SECONDS) * PFF_CLK_HZ;
  localparam longint PFF_FFC_SECS   = longint'(PFF_FFC_MINUTES) * 60;
  localparam logic [7:0] PFF_IMM_FRAMES  = 8'h36; // 54 frames
  localparam logic [7:0] PFF_BUSY_FRAMES = 8'h17; // 23 frames

  // APB register byte offsets
  localparam logic [7:0] PFF_REG_CTRL   = 8'h00;
  localparam logic [7:0] PFF_REG_CMD    = 8'h04;
  localparam logic [7:0] PFF_REG_TIME   = 8'h08;
  localparam logic [7:0] PFF_REG_DELTA  = 8'h0C;
  localparam logic [7:0] PFF_REG_STATUS = 8'h10;
  localparam logic [7:0] PFF_REG_POWER  = 8'h14;

  // Command bits
  localparam int PFF_CMD_BOOT  = 0;
  localparam int PFF_CMD_SHUT  = 1;
  localparam int PFF_CMD_WAKE  = 2;
  localparam int PFF_CMD_FFC   = 3;
endpackage : pff_pkg
`default_nettype wire

// ### verilog/pff_counter.sv
/*
 Load-and-count-down counter with terminal flag.
 Assumes a single clock and asynchronous active high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module pff_counter #(
  parameter int W = 32
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  input  wire logic         dec_i,
  output logic              zero_o
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  // Next count: load wins, otherwise step down to zero
  always_comb begin
    next_cnt = cnt;
    if (load_i) begin
      next_cnt = value_i;
    end else if (dec_i && cnt != '0) begin
      next_cnt = cnt - W'(1);
    end
  end

  // Register
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign zero_o = (cnt == '0);
endmodule : pff_counter
`default_nettype wire

// ### verilog/pff_ctrl.sv
/*
 Power state and flat field correction state controller with APB registers.
 Assumes the frame strobe and temperature input are synchronous to clk_sys_i;
 temperature is signed, 0.01 degC per count.
*/
// Design decisions made here: the APB slave port and the register addresses.
// Notes on behaviour
// - Five power states; only off to uninitialised and over-temperature entry and exit are automatic.
// - Enter over-temperature alone when temperature rises above 80 degC.
// - On over-temperature entry set shutdown-imminent and start ten-second countdown.
// - Temperature below 80 degC before expiry clears the bit, returns to on.
// - Countdown expiry moves automatically into shutdown.
// - Shutdown offers nothing; host commands move between shutdown and on.
// - Three correction modes; automatic is the reset default.
// - External mode corrects only on command; host supplies uniform scene.
// - Manual mode corrects on command with the shutter closed throughout.
// - Automatic mode corrects at start-up, on elapsed time or temperature change.
// - Host may change the time and temperature-change thresholds.
// - Correction state reported as one of four states.
// - Correction state is not commanded out of reset.
// - Imminent only in automatic mode, a set number of frames before start.
// - In progress on command or automatic start, held 23 frames.
// - Finished correction moves to complete.
// - Correction-desired flag follows the automatic trigger conditions in every mode.
// - In automatic mode desired moves the state to imminent at once.
// - Outside -10 to +65 degC shutter locks out; flagged in status.
// - Correction state in status bits 5 to 4, codes 00 to 11.
// - Shutter lockout reported in status bit 15.
// - Shutdown-imminent reported in status bit 20.
`timescale 1ns/10ps
`default_nettype none
module pff_ctrl #(
  parameter longint OT_CYCLES  = pff_pkg::PFF_OT_CYCLES,
  parameter int     SEC_CYCLES = pff_pkg::PFF_CLK_HZ
) (
  input  wire logic               clk_sys_i,
  input  wire logic               reset_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic [31:0]             prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire logic               frame_i,
  input  wire logic signed [15:0] temp_i,
  output logic [31:0]             status_o,
  output logic [2:0]              power_state_o,
  output logic                    shutter_close_o,
  output logic                    factory_terms_o
);
  pff_pkg::pff_pwr_t pwr;
  pff_pkg::pff_pwr_t next_pwr;
  logic [1:0]        mode;
  logic [1:0]        next_mode;
  logic [15:0]       time_thr;
  logic [15:0]       next_time_thr;
  logic [15:0]       delta_thr;
  logic [15:0]       next_delta_thr;
  logic [1:0]        fst;
  logic [1:0]        next_fst;
  logic [7:0]        frames;
  logic [7:0]        next_frames;
  logic              desired;
  logic              next_desired;
  logic              ran;
  logic              next_ran;
  logic signed [15:0] last_temp;
  logic signed [15:0] next_last_temp;
  logic [31:0]       secs;
  logic [31:0]       next_secs;
  logic [31:0]       prdata;
  logic [31:0]       next_prdata;
  logic              pready;
  logic              next_pready;
  logic              pslverr;
  logic              next_pslverr;
  logic              ot_load;
  logic              ot_zero;
  logic              sec_zero;
  logic              wr;
  logic              hot;
  logic              lockout;
  logic              trig;
  logic              cmd_ffc;
  logic [15:0]       tdiff;
  logic [31:0]       stat;

  // Bus write strobe on the access phase
  assign wr      = psel_i && penable_i && pwrite_i && !pready;
  assign cmd_ffc = wr && paddr_i == pff_pkg::PFF_REG_CMD && pwdata_i[pff_pkg::PFF_CMD_FFC];
  assign hot     = temp_i > pff_pkg::PFF_T_OVER;
  assign lockout = temp_i < pff_pkg::PFF_T_LOW || temp_i > pff_pkg::PFF_T_HIGH;
  assign tdiff   = (temp_i > last_temp) ? 16'(temp_i - last_temp) : 16'(last_temp - temp_i);
  // Start-up, elapsed time or temperature change since the last run
  assign trig    = pwr == pff_pkg::PFF_PWR_ON &&
                   (!ran || secs >= 32'(time_thr) || tdiff > delta_thr);

  // Over-temperature countdown, reloaded on every entry
  pff_counter #(.W(40)) u_ot (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .load_i    (ot_load),
    .value_i   (40'(OT_CYCLES)),
    .dec_i     (pwr == pff_pkg::PFF_PWR_OVERTEMP),
    .zero_o    (ot_zero)
  );

  // One second tick for the elapsed time trigger
  pff_counter #(.W(32)) u_sec (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .load_i    (sec_zero),
    .value_i   (32'(SEC_CYCLES - 1)),
    .dec_i     (1'b1),
    .zero_o    (sec_zero)
  );

  // Power state machine
  always_comb begin
    next_pwr = pwr;
    ot_load  = 1'b0;
    case (pwr)
      pff_pkg::PFF_PWR_OFF: next_pwr = pff_pkg::PFF_PWR_UNINIT;
      pff_pkg::PFF_PWR_UNINIT: begin
        if (wr && paddr_i == pff_pkg::PFF_REG_CMD && pwdata_i[pff_pkg::PFF_CMD_BOOT]) begin
          next_pwr = pff_pkg::PFF_PWR_ON;
        end
      end
      pff_pkg::PFF_PWR_ON: begin
        if (hot) begin
          next_pwr = pff_pkg::PFF_PWR_OVERTEMP;
          ot_load  = 1'b1;
        end else if (wr && paddr_i == pff_pkg::PFF_REG_CMD &&
                     pwdata_i[pff_pkg::PFF_CMD_SHUT]) begin
          next_pwr = pff_pkg::PFF_PWR_SHUTDOWN;
        end
      end
      pff_pkg::PFF_PWR_SHUTDOWN: begin
        if (wr && paddr_i == pff_pkg::PFF_REG_CMD && pwdata_i[pff_pkg::PFF_CMD_WAKE]) begin
          next_pwr = pff_pkg::PFF_PWR_ON;
        end
      end
      pff_pkg::PFF_PWR_OVERTEMP: begin
        if (!hot && temp_i < pff_pkg::PFF_T_OVER) begin
          next_pwr = pff_pkg::PFF_PWR_ON;
        end else if (ot_zero) begin
          next_pwr = pff_pkg::PFF_PWR_SHUTDOWN;
        end
      end
      default: next_pwr = pff_pkg::PFF_PWR_OFF;
    endcase
  end

  // Correction state machine and trigger bookkeeping
  always_comb begin
    next_fst       = fst;
    next_frames    = frames;
    next_ran       = ran;
    next_last_temp = last_temp;
    next_secs      = (sec_zero && secs != '1) ? secs + 32'h1 : secs;
    next_desired   = trig;
    case (fst)
      pff_pkg::PFF_FST_NOT_CMD, pff_pkg::PFF_FST_DONE: begin
        if (mode == pff_pkg::PFF_MODE_AUTO && trig && !lockout) begin
          next_fst    = pff_pkg::PFF_FST_IMMINENT;
          next_frames = pff_pkg::PFF_IMM_FRAMES;
        end else if (cmd_ffc && pwr == pff_pkg::PFF_PWR_ON &&
                     !(lockout && mode != pff_pkg::PFF_MODE_EXTERNAL)) begin
          next_fst    = pff_pkg::PFF_FST_BUSY;
          next_frames = pff_pkg::PFF_BUSY_FRAMES;
        end
      end
      pff_pkg::PFF_FST_IMMINENT: begin
        if (lockout || mode != pff_pkg::PFF_MODE_AUTO) begin
          next_fst = pff_pkg::PFF_FST_NOT_CMD;
          if (ran) begin
            next_fst = pff_pkg::PFF_FST_DONE;
          end
        end else if (frame_i) begin
          if (frames <= 8'h1) begin
            next_fst    = pff_pkg::PFF_FST_BUSY;
            next_frames = pff_pkg::PFF_BUSY_FRAMES;
          end else begin
            next_frames = frames - 8'h1;
          end
        end
      end
      pff_pkg::PFF_FST_BUSY: begin
        if (frame_i) begin
          if (frames <= 8'h1) begin
            next_fst       = pff_pkg::PFF_FST_DONE;
            next_ran       = 1'b1;
            next_last_temp = temp_i;
            next_secs      = '0;
            next_desired   = 1'b0;
          end else begin
            next_frames = frames - 8'h1;
          end
        end
      end
      default: next_fst = pff_pkg::PFF_FST_NOT_CMD;
    endcase
  end

  // Status word
  always_comb begin
    stat = '0;
    stat[pff_pkg::PFF_ST_DESIRED_BIT] = desired;
    stat[pff_pkg::PFF_ST_FSTATE_LSB +: 2] = fst;
    stat[pff_pkg::PFF_ST_LOCKOUT_BIT] = lockout;
    stat[pff_pkg::PFF_ST_SHUTDOWN_BIT] = pwr == pff_pkg::PFF_PWR_OVERTEMP;
  end

  // Register writes and APB answer, one wait state in the access phase
  always_comb begin
    next_mode      = mode;
    next_time_thr  = time_thr;
    next_delta_thr = delta_thr;
    next_prdata    = prdata;
    next_pslverr   = 1'b0;
    next_pready    = psel_i && penable_i && !pready;
    if (psel_i && penable_i && !pready) begin
      case (paddr_i)
        pff_pkg::PFF_REG_CTRL: begin
          next_prdata = {30'h0, mode};
          if (pwrite_i && pwdata_i[1:0] != 2'h3) begin
            next_mode = pwdata_i[1:0];
          end
        end
        pff_pkg::PFF_REG_CMD: next_prdata = '0;
        pff_pkg::PFF_REG_TIME: begin
          next_prdata = {16'h0, time_thr};
          if (pwrite_i) begin
            next_time_thr = pwdata_i[15:0];
          end
        end
        pff_pkg::PFF_REG_DELTA: begin
          next_prdata = {16'h0, delta_thr};
          if (pwrite_i) begin
            next_delta_thr = pwdata_i[15:0];
          end
        end
        pff_pkg::PFF_REG_STATUS: next_prdata = stat;
        pff_pkg::PFF_REG_POWER: next_prdata = {29'h0, pwr};
        default: begin
          next_prdata  = '0;
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      pwr       <= pff_pkg::PFF_PWR_OFF;
      mode      <= pff_pkg::PFF_MODE_AUTO;
      time_thr  <= 16'(pff_pkg::PFF_FFC_SECS);
      delta_thr <= pff_pkg::PFF_T_DELTA;
      fst       <= pff_pkg::PFF_FST_NOT_CMD;
      frames    <= '0;
      desired   <= 1'b0;
      ran       <= 1'b0;
      last_temp <= '0;
      secs      <= '0;
      prdata    <= '0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      status_o  <= '0;
      power_state_o   <= '0;
      shutter_close_o <= 1'b0;
      factory_terms_o <= 1'b1;
    end else begin
      pwr       <= next_pwr;
      mode      <= next_mode;
      time_thr  <= next_time_thr;
      delta_thr <= next_delta_thr;
      fst       <= next_fst;
      frames    <= next_frames;
      desired   <= next_desired;
      ran       <= next_ran;
      last_temp <= next_last_temp;
      secs      <= next_secs;
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
      status_o  <= stat;
      power_state_o   <= next_pwr;
      shutter_close_o <= next_fst == pff_pkg::PFF_FST_BUSY &&
                         next_mode != pff_pkg::PFF_MODE_EXTERNAL;
      factory_terms_o <= !next_ran;
    end
  end

  assign prdata_o  = prdata;
  assign pready_o  = pready;
  assign pslverr_o = pslverr;

  // Checks
  property p_ot_entry;
    @(posedge clk_sys_i) disable iff (reset_i)
      (pwr == pff_pkg::PFF_PWR_ON && hot) |=> pwr == pff_pkg::PFF_PWR_OVERTEMP;
  endproperty
  a_ot_entry: assert property (p_ot_entry) else $error("no overtemp entry");

  property p_ot_flag;
    @(posedge clk_sys_i) disable iff (reset_i)
      $rose(pwr == pff_pkg::PFF_PWR_OVERTEMP) |=> status_o[pff_pkg::PFF_ST_SHUTDOWN_BIT];
  endproperty
  a_ot_flag: assert property (p_ot_flag) else $error("shutdown flag missing");

  property p_ot_exit;
    @(posedge clk_sys_i) disable iff (reset_i)
      (pwr == pff_pkg::PFF_PWR_OVERTEMP && temp_i < pff_pkg::PFF_T_OVER)
        |=> pwr == pff_pkg::PFF_PWR_ON;
  endproperty
  a_ot_exit: assert property (p_ot_exit) else $error("no cool return");

  property p_ot_expire;
    @(posedge clk_sys_i) disable iff (reset_i)
      (pwr == pff_pkg::PFF_PWR_OVERTEMP && ot_zero && !(temp_i < pff_pkg::PFF_T_OVER))
        |=> pwr == pff_pkg::PFF_PWR_SHUTDOWN;
  endproperty
  a_ot_expire: assert property (p_ot_expire) else $error("no expiry shutdown");

  property p_ot_reload;
    @(posedge clk_sys_i) disable iff (reset_i)
      $rose(pwr == pff_pkg::PFF_PWR_OVERTEMP) |-> !ot_zero;
  endproperty
  a_ot_reload: assert property (p_ot_reload) else $error("countdown not reloaded");

  property p_imm_auto;
    @(posedge clk_sys_i) disable iff (reset_i)
      fst == pff_pkg::PFF_FST_IMMINENT && $changed(fst) |-> $past(mode) == pff_pkg::PFF_MODE_AUTO;
  endproperty
  a_imm_auto: assert property (p_imm_auto) else $error("imminent outside auto");

  sequence s_busy_end;
    fst == pff_pkg::PFF_FST_BUSY && frame_i && frames == 8'h1;
  endsequence
  property p_done;
    @(posedge clk_sys_i) disable iff (reset_i)
      s_busy_end |=> fst == pff_pkg::PFF_FST_DONE ##1 factory_terms_o == 1'b0;
  endproperty
  a_done: assert property (p_done) else $error("no complete state");

  property p_lock_flag;
    @(posedge clk_sys_i) disable iff (reset_i)
      lockout |=> status_o[pff_pkg::PFF_ST_LOCKOUT_BIT];
  endproperty
  a_lock_flag: assert property (p_lock_flag) else $error("lockout flag missing");

  property p_lock_noauto;
    @(posedge clk_sys_i) disable iff (reset_i)
      (lockout && fst == pff_pkg::PFF_FST_DONE) |=> fst != pff_pkg::PFF_FST_IMMINENT;
  endproperty
  a_lock_noauto: assert property (p_lock_noauto) else $error("auto run in lockout");
endmodule : pff_ctrl
`default_nettype wire

// ### sim/pff_host.sv
/*
 Host model: the processor that drives the control registers over APB.
 Assumes each task call starts right after a rising edge of clk_sys_i.
*/
`timescale 1ns/10ps
`default_nettype none
module pff_host (
  input  wire logic        clk_sys_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o
);
  // Idle bus from time zero
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 8'h00;
    pwdata_o  = 32'h00000000;
  end

  // One transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel_o   <= 1'b1;
    pwrite_o <= w;
    paddr_o  <= a;
    pwdata_o <= d;
    @(posedge clk_sys_i);
    penable_o <= 1'b1;
    @(posedge clk_sys_i);
    // No local limit: only the bench watchdog ends a wait for the answer
    while (pready_i !== 1'b1) begin
      @(posedge clk_sys_i);
    end
    q = prdata_i;
    e = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    pwdata_o  <= ~d; // Stale data is not left on the bus
  endtask : xfer
endmodule : pff_host
`default_nettype wire

// ### sim/power_and_flat_field_state_control_tb.sv
/*
 Self-checking bench for pff_ctrl, driven through the host model.
 Assumes short countdowns: OT_CYCLES 50 and SEC_CYCLES 20.
*/
`timescale 1ns/10ps
`default_nettype none
module power_and_flat_field_state_control_tb;
  logic               clk_sys_i = 1'b0;
  logic               reset_i   = 1'b1;
  logic               frame_i   = 1'b0;
  logic signed [15:0] temp_i    = 16'sh09C4;
  logic               psel, penable, pwrite, pready, pslverr, shut, fact;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, st;
  logic [2:0]         pw;
  int                 errors = 0;
  int                 num_checks = 0;

  // 40 MHz clock
  always #12.5 clk_sys_i = ~clk_sys_i;

  pff_ctrl #(.OT_CYCLES(50), .SEC_CYCLES(20)) DUT (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .frame_i(frame_i), .temp_i(temp_i),
    .status_o(st), .power_state_o(pw), .shutter_close_o(shut), .factory_terms_o(fact));

  pff_host host (
    .clk_sys_i(clk_sys_i), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata));

  // Comparison and reporting helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic conclude();
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b1, a, d, q, e);
    @(posedge clk_sys_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b0, a, 32'h00000000, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
    @(posedge clk_sys_i);
  endtask : rd

  task automatic settle();
    repeat (4) @(posedge clk_sys_i);
  endtask : settle

  task automatic frames(input int n);
    repeat (n) begin
      frame_i <= 1'b1;
      @(posedge clk_sys_i);
      frame_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
    end
  endtask : frames

  task automatic cmd(input int b);
    wr(pff_pkg::PFF_REG_CMD, 32'h00000001 << b);
    settle();
  endtask : cmd

  // Values out of reset and refused accesses
  task automatic t_reset();
    chk({29'h0, pw}, 32'h00000001);
    chk(st, 32'h00000000);
    chk({31'h0, fact}, 32'h00000001);
    rd(pff_pkg::PFF_REG_CTRL, 32'h00000002, 1'b0);
    rd(pff_pkg::PFF_REG_DELTA, 32'h0000012C, 1'b0);
    rd(pff_pkg::PFF_REG_POWER, 32'h00000001, 1'b0);
    rd(pff_pkg::PFF_REG_STATUS, 32'h00000000, 1'b0);
    wr(pff_pkg::PFF_REG_TIME, 32'h00000007);
    rd(pff_pkg::PFF_REG_TIME, 32'h00000007, 1'b0);
    wr(pff_pkg::PFF_REG_TIME, 32'h0000012C);
    wr(pff_pkg::PFF_REG_CTRL, 32'h00000003);
    rd(pff_pkg::PFF_REG_CTRL, 32'h00000002, 1'b0);
    rd(8'h20, 32'h00000000, 1'b1);
  endtask : t_reset

  // Boot, then the start-up correction in automatic mode
  task automatic t_auto();
    cmd(pff_pkg::PFF_CMD_BOOT);
    chk({29'h0, pw}, 32'h00000002);
    chk({31'h0, st[3]}, 32'h00000001);
    chk({30'h0, st[5:4]}, 32'h00000001);
    frames(53);
    chk({30'h0, st[5:4]}, 32'h00000001);
    frames(1);
    chk({30'h0, st[5:4]}, 32'h00000002);
    chk({31'h0, shut}, 32'h00000001);
    frames(22);
    chk({30'h0, st[5:4]}, 32'h00000002);
    frames(1);
    chk({30'h0, st[5:4]}, 32'h00000003);
    chk({30'h0, fact, st[3]}, 32'h00000000);
  endtask : t_auto

  // Shutter lockout in each mode, then a manual correction in range
  task automatic t_lock();
    temp_i <= 16'sh1B58;
    settle();
    chk({31'h0, st[15]}, 32'h00000001);
    chk({30'h0, st[5:4]}, 32'h00000003);
    cmd(pff_pkg::PFF_CMD_FFC);
    chk({30'h0, st[5:4]}, 32'h00000003);
    wr(pff_pkg::PFF_REG_CTRL, 32'h00000001);
    cmd(pff_pkg::PFF_CMD_FFC);
    chk({30'h0, st[5:4]}, 32'h00000003);
    wr(pff_pkg::PFF_REG_CTRL, 32'h00000000);
    cmd(pff_pkg::PFF_CMD_FFC);
    chk({29'h0, st[5:4], shut}, 32'h00000004);
    frames(23);
    chk({30'h0, st[5:4]}, 32'h00000003);
    temp_i <= 16'sh09C4;
    wr(pff_pkg::PFF_REG_CTRL, 32'h00000001);
    settle();
    chk({30'h0, st[15], st[5]}, 32'h00000001);
    cmd(pff_pkg::PFF_CMD_FFC);
    chk({29'h0, st[5:4], shut}, 32'h00000005);
    frames(23);
    chk({30'h0, st[5:4]}, 32'h00000003);
  endtask : t_lock

  // Over-temperature entry, recovery, restart of the countdown, shutdown
  task automatic t_ot();
    int n;
    n = 0;
    temp_i <= 16'sh1F41;
    settle();
    chk({29'h0, pw}, 32'h00000004);
    chk({31'h0, st[20]}, 32'h00000001);
    repeat (30) @(posedge clk_sys_i);
    temp_i <= 16'sh1F3F;
    settle();
    chk({28'h0, st[20], pw}, 32'h00000002);
    temp_i <= 16'sh1F41;
    while (pw !== 3'h3 && n < 100) begin
      n++;
      @(posedge clk_sys_i);
    end
    chk({31'h0, n >= 48 && n <= 56}, 32'h00000001);
    temp_i <= 16'sh09C4;
    cmd(pff_pkg::PFF_CMD_WAKE);
    chk({29'h0, pw}, 32'h00000002);
    cmd(pff_pkg::PFF_CMD_SHUT);
    chk({29'h0, pw}, 32'h00000003);
  endtask : t_ot

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    // The first step out of reset lands in this edge; sample one edge later
    @(posedge clk_sys_i);
    t_reset();
    t_auto();
    t_lock();
    t_ot();
    conclude();
  end

  // Watchdog against a hang
  initial begin
    repeat (8000) @(posedge clk_sys_i);
    errors++;
    conclude();
  end
endmodule : power_and_flat_field_state_control_tb
`default_nettype wire
